// ===== core/msq_defines.vh
// Function
// - After calibration the sequencer idles, powered, until monitoring is enabled.
// - Monitor-enable bit in control 1 (18h) starts monitoring in round-robin.
// - Order: supply, internal temp, diode or inputs one/two, inputs three-eight.
// - After input eight the loop restarts at supply, continuously.
// - Clearing monitor-enable stops the measurement loop.
// - Single-channel bit in control 2 (19h) holds one channel, still monitoring.
// - Averaging defaults on: sixteen readings, their mean is the result.
// - Averaging-disable bit in control 2 gives single readings.
// - Two control 1 bits choose diode sensor or analog inputs one/two.
// - Reference bit in control 3 (1Ah): zero internal, one supply.
// - Serial interface defaults I2C; SPI once chosen locks until power cycle.
// - Fast bit in control 3 raises converter clock, drops diode filters.
// - Converter starts at slow clock speed.
// - Analog results are 10-bit straight binary of reference over 1024.
// - Input flagged when above high limit or at or below low limit.
// - Eight-bit limits compare against the upper eight result bits.
// - Unmasked out-of-limit inputs set status 1 (00h) flags and interrupt.
// - Interrupt polarity selectable, default active low.
// - Serial activity aborts conversion and resets converter, restart after.
`ifndef MSQ_DEFINES_VH
`define MSQ_DEFINES_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MSQ_RI_STATUS1   8'h00
`define MSQ_RI_CTRL1     8'h18
`define MSQ_RI_CTRL2     8'h19
`define MSQ_RI_CTRL3     8'h1a
`define MSQ_RI_MASK      8'h1d
`define MSQ_RI_LIMIT     8'h20
`define MSQ_RI_RESULT    8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define MSQ_C1_MON_EN    0
`define MSQ_C1_PIN_LO    1
`define MSQ_C1_PIN_HI    2
`define MSQ_C1_INT_POL   3
`define MSQ_C2_SINGLE    4
`define MSQ_C2_AVG_DIS   5
`define MSQ_C3_FAST      0
`define MSQ_C3_REF_VDD   4

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define MSQ_RST_CTRL1    8'h00
`define MSQ_RST_CTRL2    8'h00
`define MSQ_RST_CTRL3    8'h00
`define MSQ_RST_MASK     8'h00

// ----------------------------------------------------------------
// Channel codes
// ----------------------------------------------------------------
`define MSQ_CH_VDD       4'h0
`define MSQ_CH_TINT      4'h1
`define MSQ_CH_DIODE     4'h2
`define MSQ_CH_ANALOG_IN_ONE      4'h3
`define MSQ_CH_AIN3      4'h5
`define MSQ_CH_ANALOG_IN_EIGHT      4'ha
`define MSQ_NUM_CH       11

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MSQ_CLK_FREQ_KHZ 25000
`define MSQ_CAL_TIME_US  5000
`define MSQ_CAL_CYCLES   ((`MSQ_CAL_TIME_US * `MSQ_CLK_FREQ_KHZ) / 1000)
`define MSQ_AVG_COUNT    16

`endif

// ===== core/msq_measure_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "msq_defines.vh"

module msq_measure_seq #(
   parameter CAL_CYCLES = `MSQ_CAL_CYCLES,
   parameter AW         = 10
) (
   // Clock and reset
   input  wire          I_CLK_SYS,
   input  wire          I_ARST_N,
   // AXI4-Lite write address
   input  wire          S_AXI_AWVALID,
   output wire          S_AXI_AWREADY,
   input  wire [AW-1:0] S_AXI_AWADDR,
   input  wire [2:0]    S_AXI_AWPROT,
   // AXI4-Lite write data
   input  wire          S_AXI_WVALID,
   output wire          S_AXI_WREADY,
   input  wire [31:0]   S_AXI_WDATA,
   input  wire [3:0]    S_AXI_WSTRB,
   // AXI4-Lite write response
   output wire          S_AXI_BVALID,
   input  wire          S_AXI_BREADY,
   output wire [1:0]    S_AXI_BRESP,
   // AXI4-Lite read address
   input  wire          S_AXI_ARVALID,
   output wire          S_AXI_ARREADY,
   input  wire [AW-1:0] S_AXI_ARADDR,
   input  wire [2:0]    S_AXI_ARPROT,
   // AXI4-Lite read data
   output wire          S_AXI_RVALID,
   input  wire          S_AXI_RREADY,
   output wire [31:0]   S_AXI_RDATA,
   output wire [1:0]    S_AXI_RRESP,
   // Converter
   output wire          O_CONV_START,
   output wire          O_CONV_RESET,
   output wire [3:0]    O_CONV_CHAN,
   input  wire          I_CONV_DONE,
   input  wire [9:0]    I_CONV_DATA,
   output wire          O_ADC_FAST,
   output wire          O_DIODE_FILTER_EN,
   output wire          O_REF_VDD,
   output wire          O_DIODE_MODE,
   // Serial interface status pins
   input  wire          I_SER_BUSY,
   input  wire          I_SPI_SELECT,
   output wire          O_SPI_LOCKED,
   // Status
   output wire          O_CAL_BUSY,
   output wire          O_MONITORING,
   output wire          O_INT
);

   // ----------------------------------------------------------------
   // States
   // ----------------------------------------------------------------
   localparam [3:0] ST_CAL   = 4'b0001;
   localparam [3:0] ST_IDLE  = 4'b0010;
   localparam [3:0] ST_START = 4'b0100;
   localparam [3:0] ST_WAIT  = 4'b1000;

   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [16:0] cal_cnt_q;
   reg  [3:0]  chan_q;
   reg  [3:0]  chan_d;
   reg  [3:0]  samp_q;
   reg  [13:0] acc_q;
   reg         start_q;
   reg         done_evt_q;
   reg  [9:0]  done_val_q;
   reg  [3:0]  done_ch_q;

   reg  [7:0]  ctrl1_q;
   reg  [7:0]  ctrl2_q;
   reg  [7:0]  ctrl3_q;
   reg  [7:0]  mask_q;
   reg  [7:0]  status_q;
   reg  [7:0]  lim_lo_q [0:7];
   reg  [7:0]  lim_hi_q [0:7];
   reg  [9:0]  result_q [0:`MSQ_NUM_CH-1];

   reg         ser_s1_q;
   reg         ser_s2_q;
   reg         spi_s1_q;
   reg         spi_s2_q;
   reg         spi_lock_q;
   reg         int_q;

   // ----------------------------------------------------------------
   // Synchronisers
   // ----------------------------------------------------------------
   always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         ser_s1_q   <= 1'b0;
         ser_s2_q   <= 1'b0;
         spi_s1_q   <= 1'b0;
         spi_s2_q   <= 1'b0;
         spi_lock_q <= 1'b0;
      end else begin
         ser_s1_q <= I_SER_BUSY;
         ser_s2_q <= ser_s1_q;
         spi_s1_q <= I_SPI_SELECT;
         spi_s2_q <= spi_s1_q;
         // Only a power-up reset releases the lock
         if (spi_s2_q)
            spi_lock_q <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Channel order
   // ----------------------------------------------------------------
   wire mon_en     = ctrl1_q[`MSQ_C1_MON_EN];
   wire diode_mode = ~ctrl1_q[`MSQ_C1_PIN_LO] &
                     ~ctrl1_q[`MSQ_C1_PIN_HI];
   wire single     = ctrl2_q[`MSQ_C2_SINGLE];
   wire avg_dis    = ctrl2_q[`MSQ_C2_AVG_DIS];
   wire [3:0] single_ch = (ctrl2_q[3:0] > `MSQ_CH_ANALOG_IN_EIGHT) ? `MSQ_CH_VDD
                                                        : ctrl2_q[3:0];

   always @* begin
      if (single)
         chan_d = single_ch;
      else if (chan_q == `MSQ_CH_ANALOG_IN_EIGHT)
         chan_d = `MSQ_CH_VDD;
      else if (chan_q == `MSQ_CH_TINT)
         chan_d = diode_mode ? `MSQ_CH_DIODE : `MSQ_CH_ANALOG_IN_ONE;
      else if (chan_q == `MSQ_CH_DIODE)
         chan_d = `MSQ_CH_AIN3;
      else
         chan_d = chan_q + 4'h1;
   end

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   wire [13:0] sum      = acc_q + {4'h0, I_CONV_DATA};
   wire        last     = avg_dis | ({28'h0, samp_q} == `MSQ_AVG_COUNT - 1);
   wire        cal_done = (cal_cnt_q == CAL_CYCLES[16:0]);

   always @* begin
      state_d = state_q;
      case (state_q)
         ST_CAL: begin
            if (cal_done)
               state_d = ST_IDLE;
         end
         ST_IDLE: begin
            if (mon_en && !ser_s2_q)
               state_d = ST_START;
         end
         ST_START: begin
            if (!mon_en)
               state_d = ST_IDLE;
            else if (!ser_s2_q)
               state_d = ST_WAIT;
         end
         ST_WAIT: begin
            if (!mon_en)
               state_d = ST_IDLE;
            else if (ser_s2_q)
               state_d = ST_START;
            else if (I_CONV_DONE)
               state_d = ST_START;
         end
         default: state_d = ST_CAL;
      endcase
   end

   always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         state_q    <= ST_CAL;
         cal_cnt_q  <= 17'h00000;
         chan_q     <= `MSQ_CH_VDD;
         samp_q     <= 4'h0;
         acc_q      <= 14'h0000;
         start_q    <= 1'b0;
         done_evt_q <= 1'b0;
         done_val_q <= 10'h000;
         done_ch_q  <= 4'h0;
      end else begin
         state_q    <= state_d;
         start_q    <= 1'b0;
         done_evt_q <= 1'b0;
         if (state_q == ST_CAL && !cal_done)
            cal_cnt_q <= cal_cnt_q + 17'h00001;
         if (state_q == ST_IDLE) begin
            // Every enable starts a fresh round at the supply, or at single_ch when single is set
            chan_q <= single ? single_ch : `MSQ_CH_VDD;
            samp_q <= 4'h0;
            acc_q  <= 14'h0000;
         end
         if (state_q == ST_START && state_d == ST_WAIT)
            start_q <= 1'b1;
         // Abort drops the partial average; the channel starts over
         if (state_q == ST_WAIT && ser_s2_q) begin
            samp_q <= 4'h0;
            acc_q  <= 14'h0000;
         end else if (state_q == ST_WAIT && mon_en && I_CONV_DONE) begin
            if (last) begin
               done_evt_q <= 1'b1;
               done_ch_q  <= chan_q;
               done_val_q <= avg_dis ? I_CONV_DATA : sum[13:4];
               chan_q     <= chan_d;
               samp_q     <= 4'h0;
               acc_q      <= 14'h0000;
            end else begin
               samp_q <= samp_q + 4'h1;
               acc_q  <= sum;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Results and limit compare
   // ----------------------------------------------------------------
   wire [7:0] raw_flag;

   genvar g;
   generate
      for (g = 0; g < `MSQ_NUM_CH; g = g + 1) begin : g_res
         always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
            if (!I_ARST_N)
               result_q[g] <= 10'h000;
            else if (done_evt_q && {28'h0, done_ch_q} == g)
               result_q[g] <= done_val_q;
         end
      end
      for (g = 0; g < 8; g = g + 1) begin : g_cmp
         assign raw_flag[g] = done_evt_q &&
            ({28'h0, done_ch_q} == `MSQ_CH_ANALOG_IN_ONE + g) &&
            ((done_val_q[9:2] > lim_hi_q[g]) ||
             (done_val_q[9:2] <= lim_lo_q[g]));
      end
   endgenerate

   // ----------------------------------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------------------------------
   reg            aw_have_q;
   reg            w_have_q;
   reg  [AW-1:0]  awaddr_q;
   reg  [31:0]    wdata_q;
   reg  [3:0]     wstrb_q;
   reg            bvalid_q;
   reg  [1:0]     bresp_q;
   reg            rvalid_q;
   reg  [31:0]    rdata_q;
   reg  [1:0]     rresp_q;
   reg  [31:0]    rd_mux;
   reg            rd_ok;

   assign S_AXI_AWREADY = ~aw_have_q & ~bvalid_q;
   assign S_AXI_WREADY  = ~w_have_q & ~bvalid_q;
   assign S_AXI_BVALID  = bvalid_q;
   assign S_AXI_BRESP   = bresp_q;
   assign S_AXI_ARREADY = ~rvalid_q;
   assign S_AXI_RVALID  = rvalid_q;
   assign S_AXI_RDATA   = rdata_q;
   assign S_AXI_RRESP   = rresp_q;

   wire       do_wr  = aw_have_q & w_have_q & ~bvalid_q;
   wire       do_rd  = S_AXI_ARVALID & ~rvalid_q;
   wire [7:0] wr_idx = awaddr_q[9:2];
   wire [7:0] rd_idx = S_AXI_ARADDR[9:2];
   wire       wr_lim = (wr_idx[7:3] == 5'h04);
   wire       wr_ok  = (wr_idx == `MSQ_RI_CTRL1) |
                       (wr_idx == `MSQ_RI_CTRL2) |
                       (wr_idx == `MSQ_RI_CTRL3) |
                       (wr_idx == `MSQ_RI_MASK) | wr_lim;

   always @* begin
      rd_mux = 32'h00000000;
      rd_ok  = 1'b1;
      if (rd_idx == `MSQ_RI_STATUS1)
         rd_mux[7:0] = status_q;
      else if (rd_idx == `MSQ_RI_CTRL1)
         rd_mux[7:0] = ctrl1_q;
      else if (rd_idx == `MSQ_RI_CTRL2)
         rd_mux[7:0] = ctrl2_q;
      else if (rd_idx == `MSQ_RI_CTRL3)
         rd_mux[7:0] = ctrl3_q;
      else if (rd_idx == `MSQ_RI_MASK)
         rd_mux[7:0] = mask_q;
      else if (rd_idx[7:3] == 5'h04)
         rd_mux[15:0] = {lim_hi_q[rd_idx[2:0]], lim_lo_q[rd_idx[2:0]]};
      else if (rd_idx >= `MSQ_RI_RESULT &&
               {24'h0, rd_idx} < `MSQ_RI_RESULT + `MSQ_NUM_CH)
         rd_mux[9:0] = result_q[rd_idx[3:0]];
      else
         rd_ok = 1'b0;
   end

   integer k;
   always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= {AW{1'b0}};
         wdata_q   <= 32'h00000000;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= 2'h0;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h00000000;
         rresp_q   <= 2'h0;
         ctrl1_q   <= `MSQ_RST_CTRL1;
         ctrl2_q   <= `MSQ_RST_CTRL2;
         ctrl3_q   <= `MSQ_RST_CTRL3;
         mask_q    <= `MSQ_RST_MASK;
         for (k = 0; k < 8; k = k + 1) begin
            lim_lo_q[k] <= 8'h00;
            lim_hi_q[k] <= 8'hff;
         end
      end else begin
         if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= S_AXI_AWADDR;
         end
         if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_have_q <= 1'b1;
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
         end
         if (do_wr) begin
            aw_have_q <= 1'b0;
            w_have_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= wr_ok ? 2'h0 : 2'h2;
            if (wstrb_q[0]) begin
               if (wr_idx == `MSQ_RI_CTRL1)
                  ctrl1_q <= {4'h0, wdata_q[3:0]};
               if (wr_idx == `MSQ_RI_CTRL2)
                  ctrl2_q <= {2'h0, wdata_q[5:0]};
               if (wr_idx == `MSQ_RI_CTRL3)
                  ctrl3_q <= {3'h0, wdata_q[4], 3'h0, wdata_q[0]};
               if (wr_idx == `MSQ_RI_MASK)
                  mask_q <= wdata_q[7:0];
               if (wr_lim)
                  lim_lo_q[wr_idx[2:0]] <= wdata_q[7:0];
            end
            if (wstrb_q[1] && wr_lim)
               lim_hi_q[wr_idx[2:0]] <= wdata_q[15:8];
         end
         if (bvalid_q && S_AXI_BREADY)
            bvalid_q <= 1'b0;
         if (do_rd) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? 2'h0 : 2'h2;
         end else if (rvalid_q && S_AXI_RREADY) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Status flags and interrupt pin
   // ----------------------------------------------------------------
   wire [7:0] rd_clr = (do_rd && rd_idx == `MSQ_RI_STATUS1) ? status_q
                                                          : 8'h00;
   // A new flag in the read cycle survives the clear
   wire [7:0] flag_set = raw_flag & ~mask_q;
   wire       int_pol  = ctrl1_q[`MSQ_C1_INT_POL];

   always @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         status_q <= 8'h00;
         int_q    <= 1'b1;
      end else begin
         status_q <= (status_q & ~rd_clr) | flag_set;
         int_q    <= int_pol ? (|status_q) : ~(|status_q);
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign O_CONV_START      = start_q;
   assign O_CONV_RESET      = ser_s2_q | (state_q != ST_WAIT);
   assign O_CONV_CHAN       = chan_q;
   assign O_ADC_FAST        = ctrl3_q[`MSQ_C3_FAST];
   assign O_DIODE_FILTER_EN = ~ctrl3_q[`MSQ_C3_FAST];
   assign O_REF_VDD         = ctrl3_q[`MSQ_C3_REF_VDD];
   assign O_DIODE_MODE      = diode_mode;
   assign O_SPI_LOCKED      = spi_lock_q;
   assign O_CAL_BUSY        = (state_q == ST_CAL);
   assign O_MONITORING      = (state_q == ST_START) | (state_q == ST_WAIT);
   assign O_INT             = int_q;

endmodule
`default_nettype wire

// ===== dv/msq_measure_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module msq_measure_seq_properties #(
   parameter CAL_CYCLES = 16
) (
   // Clock and reset
   input wire logic       I_CLK_SYS,
   input wire logic       I_ARST_N,
   // Converter and serial
   input wire logic       O_CONV_START,
   input wire logic       O_CONV_RESET,
   input wire logic [3:0] O_CONV_CHAN,
   input wire logic       I_CONV_DONE,
   input wire logic       O_ADC_FAST,
   input wire logic       O_DIODE_FILTER_EN,
   input wire logic       I_SER_BUSY,
   input wire logic       I_SPI_SELECT,
   input wire logic       O_SPI_LOCKED,
   // Status
   input wire logic       O_CAL_BUSY,
   input wire logic       O_MONITORING,
   input wire logic       O_INT
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_ARST_N);
   // ----------------------------------------
   // Cycles since reset, saturating
   // ----------------------------------------
   logic [31:0] cyc_q;
   always_ff @(posedge I_CLK_SYS or negedge I_ARST_N) begin
      if (!I_ARST_N)
         cyc_q <= 32'h0;
      else if (cyc_q != 32'hffffffff)
         cyc_q <= cyc_q + 32'h1;
   end
   chk_cal_holds: assert property (cyc_q + 2 < CAL_CYCLES |-> O_CAL_BUSY)
      else $error("Calibration ended early");
   chk_cal_ends: assert property (cyc_q > CAL_CYCLES + 2 |-> !O_CAL_BUSY)
      else $error("Calibration did not end");
   chk_cal_no_mon: assert property (O_CAL_BUSY |-> !O_MONITORING)
      else $error("Monitoring during calibration");
   chk_idle_quiet: assert property (!O_MONITORING && !$past(O_MONITORING) |-> !O_CONV_START)
      else $error("Sample started while idle");
   chk_start_pulse: assert property (O_CONV_START |=> !O_CONV_START)
      else $error("Start longer than one cycle");
   chk_chan_hold: assert property (O_CONV_START |=> $stable(O_CONV_CHAN))
      else $error("Channel moved after start");
   chk_next_start: assert property ((I_CONV_DONE && !O_CONV_RESET && !I_SER_BUSY) ##1 (O_MONITORING && !I_SER_BUSY) |=> O_CONV_START || !O_MONITORING)
      else $error("No restart two cycles after done");
   chk_ser_reset: assert property (I_SER_BUSY [*3] |-> O_CONV_RESET)
      else $error("Converter not reset on serial activity");
   chk_ser_nostart: assert property (I_SER_BUSY [*4] |-> !O_CONV_START)
      else $error("Sample started during serial activity");
   chk_spi_sticky: assert property (O_SPI_LOCKED |=> O_SPI_LOCKED)
      else $error("Interface lock released");
   chk_spi_lock: assert property (I_SPI_SELECT [*4] |-> O_SPI_LOCKED)
      else $error("Interface lock not taken");
   chk_filter_off: assert property (O_DIODE_FILTER_EN != O_ADC_FAST)
      else $error("Filter state wrong for speed");
   chk_int_idle: assert property (O_CAL_BUSY |-> O_INT)
      else $error("Interrupt active at power up");
   chk_slow_boot: assert property (O_CAL_BUSY |-> !O_ADC_FAST)
      else $error("Fast speed at power up");
   cov_wrap: cover property (O_CONV_START && O_CONV_CHAN == 4'ha);
   cov_lock: cover property ($rose(O_SPI_LOCKED));
   cov_int: cover property ($fell(O_INT));
endmodule
bind msq_measure_seq msq_measure_seq_properties #(.CAL_CYCLES(CAL_CYCLES))
   u_msq_measure_seq_properties (
   .I_CLK_SYS(I_CLK_SYS), .I_ARST_N(I_ARST_N), .O_CONV_START(O_CONV_START),
   .O_CONV_RESET(O_CONV_RESET), .O_CONV_CHAN(O_CONV_CHAN),
   .I_CONV_DONE(I_CONV_DONE), .O_ADC_FAST(O_ADC_FAST),
   .O_DIODE_FILTER_EN(O_DIODE_FILTER_EN), .I_SER_BUSY(I_SER_BUSY),
   .I_SPI_SELECT(I_SPI_SELECT), .O_SPI_LOCKED(O_SPI_LOCKED),
   .O_CAL_BUSY(O_CAL_BUSY), .O_MONITORING(O_MONITORING), .O_INT(O_INT));
`default_nettype wire

// ===== dv/msq_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
module msq_conv_model #(
   parameter int LAT = 3
) (
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst_n,
   // Converter control
   input  wire logic       i_start,
   input  wire logic       i_conv_reset,
   input  wire logic [3:0] i_chan,
   output var  logic       o_done,
   output var  logic [9:0] o_data
);
   int   cnt_q;
   logic odd_q;
   logic first_q;
   // Samples alternate base and base+2, so a 16-sample mean is base+1
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_q <= 0;
         odd_q <= 1'b0;
         first_q <= 1'b0;
         o_done <= 1'b0;
         o_data <= 10'h000;
      end else begin
         o_done <= 1'b0;
         o_data <= ~o_data;
         first_q <= i_start;
         if (i_start)
            cnt_q <= odd_q ? LAT + 4 : LAT;
         else if (i_conv_reset && !first_q)
            cnt_q <= 0;
         else if (cnt_q == 1) begin
            o_done <= 1'b1;
            o_data <= {i_chan, 6'h10} + (odd_q ? 10'h002 : 10'h000);
            odd_q <= ~odd_q;
            cnt_q <= 0;
         end else if (cnt_q > 1)
            cnt_q <= cnt_q - 1;
      end
   end
endmodule
`default_nettype wire

// ===== dv/msq_measure_seq_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "msq_defines.vh"
module msq_measure_seq_tb_top;
   localparam int CAL = 16;
   logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bry = 1'b0;
   logic arv = 1'b0, rry = 1'b0, busy = 1'b0, spi = 1'b0;
   logic [9:0] awa = 10'h000, ara = 10'h000, cd;
   logic [31:0] wd = 32'h0, rd;
   logic awrdy, wrdy, bv, arrdy, rv, st, crst, done, fast, filt, refv;
   logic dmode, lock, calb, mon, intr;
   logic [1:0] br, rr;
   logic [3:0] ch;
   logic [3:0] sq[$];
   int err_total = 0, n_compared = 0;
   always #20 clk = ~clk;
   always @(posedge clk) if (st) sq.push_back(ch);
   msq_measure_seq #(.CAL_CYCLES(CAL)) u_msq_measure_seq (
      .I_CLK_SYS(clk), .I_ARST_N(rst_n),
      .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_AWADDR(awa),
      .S_AXI_AWPROT(3'h0), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
      .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf), .S_AXI_BVALID(bv),
      .S_AXI_BREADY(bry), .S_AXI_BRESP(br), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arrdy), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(rry), .S_AXI_RDATA(rd),
      .S_AXI_RRESP(rr), .O_CONV_START(st), .O_CONV_RESET(crst),
      .O_CONV_CHAN(ch), .I_CONV_DONE(done), .I_CONV_DATA(cd),
      .O_ADC_FAST(fast), .O_DIODE_FILTER_EN(filt), .O_REF_VDD(refv),
      .O_DIODE_MODE(dmode), .I_SER_BUSY(busy), .I_SPI_SELECT(spi),
      .O_SPI_LOCKED(lock), .O_CAL_BUSY(calb), .O_MONITORING(mon),
      .O_INT(intr));
   msq_conv_model #(.LAT(3)) u_msq_conv_model (
      .i_clk(clk), .i_rst_n(rst_n), .i_start(st), .i_conv_reset(crst),
      .i_chan(ch), .o_done(done), .o_data(cd));
   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic check(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d,
                         output logic [1:0] r);
      logic a, w;
      a = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awa <= {idx, 2'b00};
      wd <= {16'h0000, d};
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
      while (!(a && w)) begin
         @(posedge clk);
         if (awv && awrdy) begin
            a = 1'b1;
            awv <= 1'b0;
         end
         if (wv && wrdy) begin
            w = 1'b1;
            wv <= 1'b0;
         end
      end
      do @(posedge clk); while (!bv);
      r = br;
      bry <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
                         output logic [1:0] r);
      @(posedge clk);
      ara <= {idx, 2'b00};
      arv <= 1'b1;
      rry <= 1'b1;
      do @(posedge clk); while (!arrdy);
      arv <= 1'b0;
      do @(posedge clk); while (!rv);
      d = rd;
      r = rr;
      rry <= 1'b0;
   endtask
   task automatic reg_wr(input logic [7:0] idx, input logic [15:0] d);
      logic [1:0] r;
      axi_wr(idx, d, r);
      check(r, 2'b00);
   endtask
   task automatic rd_chk(input logic [7:0] idx, input logic [31:0] m, e);
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(idx, d, r);
      check({r, d & m}, {2'b00, e});
   endtask
   task automatic wait_starts(input int n);
      sq.delete();
      while (sq.size() < n) @(posedge clk);
   endtask
   function automatic logic [9:0] base(input logic [3:0] c);
      base = {c, 6'h10};
   endfunction
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_boot;
      check(calb, 1'b1);
      repeat (CAL + 30) @(posedge clk);
      check({calb, mon, fast, filt, intr, lock}, 6'b000110);
   endtask
   task automatic t_bus;
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(8'h30, 16'h1234, r);
      check(r, 2'b10);
      axi_rd(8'h30, d, r);
      check({r, d}, {2'b10, 32'h0});
      rd_chk(`MSQ_RI_LIMIT + 8'h01, 32'hffff, 32'hff00);
   endtask
   task automatic t_rr(input logic [1:0] pin);
      logic [3:0] e;
      reg_wr(`MSQ_RI_CTRL1, 16'h0000);
      @(posedge clk);
      check(mon, 1'b0);
      reg_wr(`MSQ_RI_CTRL2, 16'h0020);
      sq.delete();
      reg_wr(`MSQ_RI_CTRL1, {13'h0, pin, 1'b1});
      check(dmode, pin == 2'b00);
      while (sq.size() < 20) @(posedge clk);
      e = `MSQ_CH_VDD;
      for (int i = 0; i < 20; i++) begin
         check(sq[i], e);
         if (e == `MSQ_CH_ANALOG_IN_EIGHT) e = `MSQ_CH_VDD;
         else if (e == `MSQ_CH_TINT)
            e = (pin == 2'b00) ? `MSQ_CH_DIODE : `MSQ_CH_ANALOG_IN_ONE;
         else if (e == `MSQ_CH_DIODE) e = `MSQ_CH_AIN3;
         else e = e + 4'h1;
      end
      for (int c = 5; c <= 10; c++)
         rd_chk(`MSQ_RI_RESULT + c[7:0], 32'h3fd, {22'h0, base(c[3:0])});
   endtask
   task automatic t_avg;
      reg_wr(`MSQ_RI_CTRL2, 16'h0017);
      wait_starts(40);
      for (int i = 20; i < 40; i++) check(sq[i], 4'h7);
      check(mon, 1'b1);
      rd_chk(`MSQ_RI_RESULT + 8'h07, 32'h3ff, {22'h0, base(4'h7) + 10'h1});
   endtask
   task automatic t_limits;
      logic [25:0] rows[5] = '{{8'h34, 8'hff, 8'h00, 2'b01},
         {8'h33, 8'h34, 8'h00, 2'b00}, {8'h33, 8'h33, 8'h00, 2'b01},
         {8'h34, 8'hff, 8'h01, 2'b00}, {8'h34, 8'hff, 8'h00, 2'b11}};
      logic [25:0] r;
      logic [31:0] d;
      logic [1:0] rs;
      reg_wr(`MSQ_RI_CTRL2, 16'h0013);
      foreach (rows[i]) begin
         r = rows[i];
         reg_wr(`MSQ_RI_LIMIT, {r[17:10], r[25:18]});
         reg_wr(`MSQ_RI_MASK, {8'h00, r[9:2]});
         reg_wr(`MSQ_RI_CTRL1, {12'h000, r[1], 3'b111});
         wait_starts(34);
         axi_rd(`MSQ_RI_STATUS1, d, rs);
         wait_starts(34);
         check(intr, 1'(~(r[0] ^ r[1])));
         axi_rd(`MSQ_RI_STATUS1, d, rs);
         check(d & 32'hff, {31'h0, r[0]});
      end
   endtask
   task automatic t_misc;
      reg_wr(`MSQ_RI_CTRL3, 16'h0011);
      check({fast, filt, refv}, 3'b101);
      reg_wr(`MSQ_RI_CTRL3, 16'h0000);
      check({fast, filt, refv}, 3'b010);
      busy <= 1'b1;
      repeat (4) @(posedge clk);
      sq.delete();
      repeat (12) @(posedge clk);
      check({crst, sq.size() == 0}, 2'b11);
      busy <= 1'b0;
      wait_starts(2);
      spi <= 1'b1;
      repeat (6) @(posedge clk);
      spi <= 1'b0;
      repeat (6) @(posedge clk);
      check(lock, 1'b1);
      reg_wr(`MSQ_RI_CTRL1, 16'h0000);
      @(posedge clk);
      sq.delete();
      repeat (60) @(posedge clk);
      check({mon, sq.size() == 0}, 2'b01);
   endtask
   task automatic summarize;
      $display("Compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_boot;
      t_bus;
      t_rr(2'b00);
      t_rr(2'b11);
      t_avg;
      t_limits;
      t_misc;
      summarize;
   end
   initial begin
      #(40 * 40000);
      err_total++;
      summarize;
   end
endmodule
`default_nettype wire
